// ===== flash_pkg.sv
// Purpose: Constants and types for the flash controller.
// Assumes: 25 MHz clock, 24-bit program words.
// Notes: Offsets are core byte addresses.
package flash_pkg;
  // Register offsets in the core's special-function space.
  localparam logic [15:0] OFF_OP_CONTROL = 16'h0760;
  localparam logic [15:0] OFF_ADDR_LOW = 16'h0762;
  localparam logic [15:0] OFF_ADDR_HIGH = 16'h0764;
  localparam logic [15:0] OFF_UNLOCK_KEY = 16'h0766;
  // Control register field positions.
  localparam int BIT_START = 15;
  localparam int BIT_WRITE_ENABLE = 14;
  localparam int BIT_WRITE_ERROR = 13;
  localparam int BIT_TWRI = 8;
  localparam int OPCODE_MSB = 6;
  // Bits software may store directly: enable, error, TWRI and the opcode.
  localparam logic [15:0] CTRL_SW_MASK = 16'h617f;
  // Values after reset.
  localparam logic [15:0] CTRL_RESET = 16'h0000;
  localparam logic [15:0] ADDR_LOW_RESET = 16'h0000;
  localparam logic [7:0] ADDR_HIGH_RESET = 8'h00;
  // Unlock key values, written back to back.
  localparam logic [7:0] KEY_FIRST = 8'h55;
  localparam logic [7:0] KEY_SECOND = 8'haa;
  // Operation codes for program flash.
  localparam logic [6:0] OPC_ERASE_ROW = 7'h41;
  localparam logic [6:0] OPC_PROGRAM_ROW = 7'h01;
  // Row and panel geometry.
  localparam int ROW_WORDS = 32;
  localparam int PANEL_ROWS = 128;
  localparam int IDX_W = $clog2(ROW_WORDS);
  localparam int ROW_W = $clog2(PANEL_ROWS);
  localparam int ROW_LSB = IDX_W + 1;
  localparam int PANEL_LSB = ROW_LSB + ROW_W;
  localparam int PANEL_W = 24 - PANEL_LSB;
  // Operation time and its cycle count at the system clock rate.
  localparam int CLK_KHZ = 25000;
  localparam int OP_TIME_US = 2000;
  localparam int OP_CYCLES = OP_TIME_US * CLK_KHZ / 1000;
  localparam int OP_CNT_W = 17;
  // Table write occupies one extra stall cycle.
  localparam logic [1:0] TBLWR_STALL_CYCLES = 2'd1;

  // Operation sequencer states, Gray coded along idle-run-finish.
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_RUN = 2'b01,
    ST_FINISH = 2'b11
  } op_state_t;
endpackage : flash_pkg

// ===== latch_if.sv
// Purpose: Controller to latch bank carrier.
// Assumes: One clock for both ends.
// Notes: Write and read ports are independent.
`timescale 1ns/1ps
interface latch_if;
  import flash_pkg::*;
  logic wrLow;           // Table write to bits 15:0.
  logic wrHigh;          // Table write to bits 23:16.
  logic byteMode;        // Byte-wide transfer.
  logic byteSel;         // Odd byte selected in byte mode.
  logic [IDX_W-1:0] wrIdx; // Latch slot written.
  logic [15:0] wrData;   // Source word.
  logic [IDX_W-1:0] rdIdx; // Latch slot read by the array.
  logic [23:0] rdData;   // Latch word read by the array.
  modport ctrl (output wrLow, wrHigh, byteMode, byteSel, wrIdx, wrData, rdIdx, input rdData);
  modport bank (input wrLow, wrHigh, byteMode, byteSel, wrIdx, wrData, rdIdx, output rdData);
endinterface : latch_if

// ===== write_latch_bank.sv
// Purpose: One row of programming data.
// Assumes: One table write at a time.
// Notes: Contents reset to zero and survive operations.
`timescale 1ns/1ps
module write_latch_bank
  import flash_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rstn,
  latch_if.bank lat
);
  // Latch storage, addressed by slot index.
  logic [23:0] mem_q [ROW_WORDS];

  // Byte merges for each kind of table write.
  wire [15:0] lowMerged = !lat.byteMode ? lat.wrData :
    (lat.byteSel ? {lat.wrData[7:0], mem_q[lat.wrIdx][7:0]} : {mem_q[lat.wrIdx][15:8], lat.wrData[7:0]});
  // High part takes only the low source byte; odd byte in byte mode is a phantom.
  wire highTakes = lat.wrHigh && !(lat.byteMode && lat.byteSel); // [RULE20]

  // One slot updated per table write; only the latches change, never the array.
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      for (int i = 0; i < ROW_WORDS; i++) begin
        mem_q[i] <= 24'h000000;
      end
    end else begin
      if (lat.wrLow) begin
        mem_q[lat.wrIdx][15:0] <= lowMerged; // [RULE5] [RULE6] [RULE9]
      end
      if (highTakes) begin
        mem_q[lat.wrIdx][23:16] <= lat.wrData[7:0]; // [RULE5] [RULE20]
      end
    end
  end

  // Array reads the slot it is programming.
  assign lat.rdData = mem_q[lat.rdIdx]; // [RULE3]
endmodule : write_latch_bank

// ===== op_timer.sv
// Purpose: Times one operation.
// Assumes: Start is a pulse while idle.
// Notes: Abort stops without a done pulse.
`timescale 1ns/1ps
module op_timer
  import flash_pkg::*;
#(
  parameter int OpCycles = OP_CYCLES
) (
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic start,
  input wire logic abort,
  output logic busy,
  output logic done
);
  logic [OP_CNT_W-1:0] cnt_q; // Cycles remaining.
  logic busy_q;               // Operation in progress.
  localparam logic [OP_CNT_W-1:0] LOAD = OP_CNT_W'(OpCycles - 1);

  wire lastCycle = busy_q && (cnt_q == '0);

  // Count down from the operation length; the last cycle ends it.
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      cnt_q <= '0;
      busy_q <= 1'b0;
    end else if (abort) begin
      busy_q <= 1'b0;
    end else if (start && !busy_q) begin
      cnt_q <= LOAD;
      busy_q <= 1'b1; // [RULE15]
    end else if (busy_q) begin
      cnt_q <= cnt_q - OP_CNT_W'(1);
      busy_q <= !lastCycle;
    end
  end

  assign busy = busy_q;
  assign done = lastCycle && !abort;
endmodule : op_timer

// ===== flash_self_program_ctrl.sv
// Purpose: Self-programming controller for program flash.
// Assumes: Core strobes last one clk_sys cycle.
// Notes: Register writes and table accesses made while cpuStall is high are ignored; register reads still answer.
// How it works
// [RULE1] Erase or program one 32-word row.
// [RULE2] Row and panel come from captured address.
// [RULE3] Latches hold the row's data before programming.
// [RULE4] Core loads latches in order, row-aligned.
// [RULE5] Low part is bits 15:0, high 23:16.
// [RULE6] Both parts allow word or byte transfers.
// [RULE7] Address is page byte joined to effective address.
// [RULE8] Core issues 32 low and 32 high writes.
// [RULE9] Table write touches latches only, two cycles.
// [RULE10] Low address captures effective address bits 15:0.
// [RULE11] High address captures address bits 23:16.
// [RULE12] Software may write both address registers.
// [RULE13] Key register write-only; 0x55 then 0xAA.
// [RULE14] Start bit 15 begins op, clears at end.
// [RULE15] Operation lasts 2 ms, core stalled throughout.
// [RULE16] Control selects blocks, memory, erase or program.
// [RULE17] Core sets control and enable before erase.
// [RULE18] Core blocks low-priority interrupts during unlock.
// [RULE19] Core executes two no-ops after start.
// [RULE20] High write uses only source low byte.
// [RULE21] Software cannot clear the start bit.
// [RULE22] Write enable clear at reset, gates writes.
// [RULE23] Reset during operation sets error, keeps address.
// [RULE24] Done flag set at completion until cleared.
// [RULE25] Keys must be back to back, else disarm.
// [RULE26] Start without enable is dropped entirely.
`timescale 1ns/1ps
module flash_self_program_ctrl
  import flash_pkg::*;
#(
  parameter int OpCycles = OP_CYCLES
) (
  input wire logic clk_sys,
  input wire logic rstn,
  // Register port from the core.
  input wire logic regWr,
  input wire logic regRd,
  input wire logic [15:0] regAddr,
  input wire logic [15:0] regWrData,
  output logic [15:0] regRdData,
  // Table instruction port from the core.
  input wire logic tblReq,
  input wire logic tblWrite,
  input wire logic tblHigh,
  input wire logic tblByte,
  input wire logic [7:0] tablePage,
  input wire logic [15:0] effectiveAddr,
  input wire logic [15:0] tblWrData,
  output logic [15:0] tblRdData,
  output logic tblRdValid,
  output logic cpuStall,
  // Reset events that can interrupt an operation.
  input wire logic resetAbort,
  // Done flag handling toward the interrupt controller.
  input wire logic doneFlagClr,
  output logic memOpDoneFlag,
  // Flash array side.
  output logic [23:0] arrRdAddr,
  input wire logic [23:0] arrRdData,
  output logic arrErase,
  output logic arrProgram,
  output logic [ROW_W-1:0] arrRowSel,
  output logic [PANEL_W-1:0] arrPanelSel,
  input wire logic [IDX_W-1:0] arrLatchIdx,
  output logic [23:0] arrLatchData
);
  latch_if lat();

  // Control and address registers.
  logic [15:0] ctrl_q;        // Control register image.
  logic [15:0] addrLow_q;     // Low program address.
  logic [7:0] addrHigh_q;     // High program address byte.
  logic keyFirst_q;           // First key seen on the previous register write.
  logic armed_q;              // Both keys seen back to back.
  logic latchLoaded_q;        // At least one latch write since last program.
  logic doneFlag_q;           // Sticky completion flag.
  op_state_t state_q;         // Sequencer state.
  op_state_t state_d;
  logic opErase_q;            // Running operation is an erase.
  logic [ROW_W-1:0] row_q;    // Row latched at start.
  logic [PANEL_W-1:0] panel_q; // Panel latched at start.
  logic [1:0] tblStall_q;     // Extra stall cycles after a table write.
  logic [23:0] rdAddr_q;      // Program address being read.
  logic rdPend_q;             // Read issued, data due next cycle.
  logic rdHigh_q;             // Pending read is the high part.
  logic rdByte_q;             // Pending read is byte-wide.
  logic [15:0] rdData_q;      // Read result toward the core.
  logic rdValid_q;            // Read result valid pulse.

  // Decode of the register port.
  wire selCtrl = (regAddr == OFF_OP_CONTROL);
  wire selLow = (regAddr == OFF_ADDR_LOW);
  wire selHigh = (regAddr == OFF_ADDR_HIGH);
  wire selKey = (regAddr == OFF_UNLOCK_KEY);
  wire busy = (state_q != ST_IDLE);
  wire accept = !cpuStall;
  wire wrCtrl = accept && regWr && selCtrl;
  wire wrLow = accept && regWr && selLow;
  wire wrHigh = accept && regWr && selHigh;
  wire wrKey = accept && regWr && selKey;
  wire [7:0] keyVal = regWrData[7:0];

  // Start request and its qualifiers.
  wire [6:0] opcode = ctrl_q[OPCODE_MSB:0];
  wire [6:0] newOpcode = regWrData[OPCODE_MSB:0];
  wire newEnable = regWrData[BIT_WRITE_ENABLE];
  wire newErase = (newOpcode == OPC_ERASE_ROW);
  wire newProgram = (newOpcode == OPC_PROGRAM_ROW) && latchLoaded_q; // [RULE3]
  wire startReq = wrCtrl && regWrData[BIT_START];
  wire startOk = startReq && armed_q && newEnable && (newErase || newProgram); // [RULE13] [RULE22] [RULE26]

  // Table access decode; the full address is page byte over effective address.
  wire tblTake = accept && tblReq;
  wire tblWr = tblTake && tblWrite;
  wire tblRd = tblTake && !tblWrite;
  wire [23:0] tblAddr = {tablePage, effectiveAddr}; // [RULE7]
  wire [23:0] opAddr = {addrHigh_q, addrLow_q};

  // Timer for the 2 ms operation.
  wire timerBusy;
  wire timerDone;

  op_timer #(
    .OpCycles(OpCycles)
  ) u_timer (
    .clk_sys(clk_sys),
    .rstn(rstn),
    .start(startOk),
    .abort(resetAbort),
    .busy(timerBusy),
    .done(timerDone)
  );

  // Latch bank write and read paths; slot is the word index within the row.
  assign lat.wrLow = tblWr && !tblHigh; // [RULE9]
  assign lat.wrHigh = tblWr && tblHigh;
  assign lat.byteMode = tblByte; // [RULE6]
  assign lat.byteSel = effectiveAddr[0];
  assign lat.wrIdx = effectiveAddr[IDX_W:1]; // [RULE4]
  assign lat.wrData = tblWrData;
  assign lat.rdIdx = arrLatchIdx;

  write_latch_bank u_latches (
    .clk_sys(clk_sys),
    .rstn(rstn),
    .lat(lat)
  );

  // Sequencer next state: run for the timed length, then one finish cycle.
  always_comb begin
    state_d = state_q;
    unique case (state_q)
      ST_IDLE: begin
        if (startOk) begin
          state_d = ST_RUN; // [RULE14]
        end
      end
      ST_RUN: begin
        if (resetAbort) begin
          state_d = ST_IDLE;
        end else if (timerDone) begin
          state_d = ST_FINISH;
        end
      end
      ST_FINISH: begin
        state_d = ST_IDLE;
      end
      default: begin
        state_d = ST_IDLE;
      end
    endcase
  end

  // Sequencer state and the operation's row, panel and kind.
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      state_q <= ST_IDLE;
      opErase_q <= 1'b0;
      row_q <= '0;
      panel_q <= '0;
    end else begin
      state_q <= state_d;
      if (startOk) begin
        opErase_q <= newErase; // [RULE16]
        row_q <= opAddr[PANEL_LSB-1:ROW_LSB]; // [RULE2] [RULE10]
        panel_q <= opAddr[23:PANEL_LSB]; // [RULE2]
      end
    end
  end

  // Control register; software cannot touch the start bit directly.
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      ctrl_q <= CTRL_RESET; // [RULE22]
    end else begin
      if (wrCtrl) begin
        ctrl_q <= (ctrl_q & ~CTRL_SW_MASK) | (regWrData & CTRL_SW_MASK); // [RULE16] [RULE21]
      end
      if (startOk) begin
        ctrl_q[BIT_START] <= 1'b1; // [RULE14]
      end else if (state_q == ST_FINISH || (busy && resetAbort)) begin
        ctrl_q[BIT_START] <= 1'b0; // [RULE14] [RULE21]
      end
      // An interrupted operation leaves an error mark; setting beats a clear.
      if (busy && resetAbort) begin
        ctrl_q[BIT_WRITE_ERROR] <= 1'b1; // [RULE23]
      end
    end
  end

  // Address registers follow every table access and direct writes alike.
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      addrLow_q <= ADDR_LOW_RESET;
      addrHigh_q <= ADDR_HIGH_RESET;
    end else if (tblTake) begin
      addrLow_q <= tblAddr[15:0]; // [RULE10]
      addrHigh_q <= tblAddr[23:16]; // [RULE11]
    end else begin
      if (wrLow) begin
        addrLow_q <= regWrData; // [RULE12]
      end
      if (wrHigh) begin
        addrHigh_q <= regWrData[7:0]; // [RULE12]
      end
    end
  end

  // Unlock tracking: any other register write breaks the key pair.
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      keyFirst_q <= 1'b0;
      armed_q <= 1'b0;
    end else if (accept && regWr) begin
      keyFirst_q <= wrKey && (keyVal == KEY_FIRST); // [RULE25]
      armed_q <= wrKey && keyFirst_q && (keyVal == KEY_SECOND); // [RULE13] [RULE25]
    end
  end

  // Latch-loaded mark: a program with empty latches is not started.
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      latchLoaded_q <= 1'b0;
    end else if (tblWr) begin
      latchLoaded_q <= 1'b1; // [RULE3]
    end else if (startOk && !newErase) begin
      latchLoaded_q <= 1'b0;
    end
  end

  // Done flag: completion wins over a same-cycle clear.
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      doneFlag_q <= 1'b0;
    end else if (state_q == ST_FINISH) begin
      doneFlag_q <= 1'b1; // [RULE24]
    end else if (doneFlagClr) begin
      doneFlag_q <= 1'b0;
    end
  end

  // A table write holds the core one extra cycle so it spans two cycles.
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      tblStall_q <= 2'd0;
    end else if (tblWr) begin
      tblStall_q <= TBLWR_STALL_CYCLES; // [RULE9]
    end else if (tblStall_q != 2'd0) begin
      tblStall_q <= tblStall_q - 2'd1;
    end
  end

  // Table read: address in one cycle, part selection the next.
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      rdAddr_q <= 24'h000000;
      rdPend_q <= 1'b0;
      rdHigh_q <= 1'b0;
      rdByte_q <= 1'b0;
      rdData_q <= 16'h0000;
      rdValid_q <= 1'b0;
    end else begin
      rdPend_q <= tblRd;
      rdValid_q <= rdPend_q;
      if (tblRd) begin
        rdAddr_q <= tblAddr; // [RULE7]
        rdHigh_q <= tblHigh;
        rdByte_q <= tblByte;
      end
      if (rdPend_q) begin
        rdData_q <= readPart(arrRdData, rdHigh_q, rdByte_q, rdAddr_q[0]); // [RULE5] [RULE6]
      end
    end
  end

  // Selects the low or high part of a program word, word or byte wide.
  function automatic logic [15:0] readPart(input logic [23:0] w, input logic hi, input logic bm, input logic odd);
    logic [15:0] r;
    r = hi ? {8'h00, w[23:16]} : w[15:0];
    if (bm) begin
      r = hi ? (odd ? 16'h0000 : {8'h00, w[23:16]}) : {8'h00, (odd ? w[15:8] : w[7:0])};
    end
    return r;
  endfunction : readPart

  // Register read mux; the key register reads as zero.
  assign regRdData = !regRd ? 16'h0000 :
    selCtrl ? ctrl_q :
    selLow ? addrLow_q :
    selHigh ? {8'h00, addrHigh_q} : 16'h0000; // [RULE13]

  // Core stall covers the whole operation and the table write's second cycle.
  assign cpuStall = busy || timerBusy || (tblStall_q != 2'd0); // [RULE15] [RULE9]
  assign tblRdData = rdData_q;
  assign tblRdValid = rdValid_q;
  assign memOpDoneFlag = doneFlag_q;
  assign arrRdAddr = rdAddr_q;
  assign arrErase = (state_q == ST_RUN) && opErase_q; // [RULE1]
  assign arrProgram = (state_q == ST_RUN) && !opErase_q; // [RULE1]
  assign arrRowSel = row_q;
  assign arrPanelSel = panel_q;
  assign arrLatchData = lat.rdData;
endmodule : flash_self_program_ctrl

// ===== flash_ctrl_assertions.sv
// Purpose: Port checks for the flash controller.
// Assumes: One clock, synchronous active-low reset.
// Notes: A stall run counter judges operation length.
`timescale 1ns/1ps
module flash_ctrl_assertions
  import flash_pkg::*;
#(
  parameter int OpCycles = OP_CYCLES
) (
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic regWr,
  input wire logic regRd,
  input wire logic [15:0] regAddr,
  input wire logic [15:0] regWrData,
  input wire logic [15:0] regRdData,
  input wire logic tblReq,
  input wire logic tblWrite,
  input wire logic tblRdValid,
  input wire logic cpuStall,
  input wire logic resetAbort,
  input wire logic doneFlagClr,
  input wire logic memOpDoneFlag,
  input wire logic arrErase,
  input wire logic arrProgram
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rstn);
  logic [16:0] stallCnt_q; // Stall run length.
  logic abortSeen_q; // Abort seen in this stall.
  // Aborted runs end early on purpose, so they are exempt.
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      stallCnt_q <= 17'h00000;
      abortSeen_q <= 1'b0;
    end else begin
      stallCnt_q <= cpuStall ? stallCnt_q + 17'h00001 : 17'h00000;
      abortSeen_q <= cpuStall && (abortSeen_q || resetAbort);
    end
  end
  a_write_stall: assert property (tblReq && tblWrite && !cpuStall |=> cpuStall ##1 !cpuStall)
    else $error("write stall");
  a_read_answer: assert property (tblReq && !tblWrite && !cpuStall |-> ##2 tblRdValid)
    else $error("read answer");
  a_op_stalls: assert property ($rose(arrErase || arrProgram) |-> cpuStall)
    else $error("no stall");
  a_op_length: assert property ($fell(cpuStall) && stallCnt_q > 1 && !abortSeen_q |->
    stallCnt_q == OpCycles + 1) else $error("op length");
  a_done_at_end: assert property ($fell(cpuStall) && stallCnt_q > 1 && !abortSeen_q |-> memOpDoneFlag)
    else $error("no done");
  a_done_sticky: assert property (memOpDoneFlag && !doneFlagClr |=> memOpDoneFlag)
    else $error("done dropped");
  a_erase_unlock: assert property ($rose(arrErase) |-> $past(regWr) && $past(regAddr) == OFF_OP_CONTROL
    && $past(regWrData) == 16'hc041 && $past(regWrData, 2) == 16'h00aa && $past(regWrData, 3) == 16'h0055)
    else $error("erase no unlock");
  a_prog_start: assert property ($rose(arrProgram) |-> $past(regWr) && $past(regWrData) == 16'hc001)
    else $error("prog no start");
  a_abort_ends: assert property (resetAbort && cpuStall |-> ##[1:3] !cpuStall)
    else $error("abort hang");
  a_idle_read: assert property (!regRd |-> regRdData == 16'h0000)
    else $error("idle read");
  c_erase: cover property ($rose(arrErase));
  c_program: cover property ($rose(arrProgram));
  c_read: cover property (tblRdValid);
  c_abort: cover property (resetAbort && cpuStall);
endmodule : flash_ctrl_assertions

// ===== flash_array_model.sv
// Purpose: Flash array model at the controller's array side.
// Assumes: Read data follows the address at once.
// Notes: Reads show a fixed pattern; programming fills img.
`timescale 1ns/1ps
module flash_array_model
  import flash_pkg::*;
(
  input wire logic clk_sys,
  input wire logic [23:0] arrRdAddr,
  output logic [23:0] arrRdData,
  input wire logic arrProgram,
  output logic [IDX_W-1:0] arrLatchIdx,
  input wire logic [23:0] arrLatchData
);
  logic [23:0] img [ROW_WORDS]; // Row last taken from the latches.
  logic [IDX_W-1:0] slot_q = '0; // Latch slot being fetched.
  // Pattern of the word address; address bit 0 is unused.
  assign arrRdData = {~arrRdAddr[8:1], arrRdAddr[16:1] ^ 16'h5a5a};
  assign arrLatchIdx = slot_q;
  // Sweep every latch slot while programming and keep its word.
  always @(posedge clk_sys) begin
    if (arrProgram) begin
      img[slot_q] <= arrLatchData;
      slot_q <= slot_q + 1'b1;
    end else begin
      slot_q <= '0;
    end
  end
endmodule : flash_array_model

// ===== flash_self_program_ctrl_tb.sv
// Purpose: Self-checking bench for the flash controller.
// Assumes: Inputs move on rising edges, outputs read at falling edges.
// Notes: A short operation still sweeps every latch slot.
`timescale 1ns/1ps
module flash_self_program_ctrl_tb;
  import flash_pkg::*;
  localparam int OpCyc = 40; // Covers 32 slots.
  logic clk_sys = 1'b0, rstn = 1'b0, regWr = 1'b0, regRd = 1'b0, tblReq = 1'b0, tblWrite = 1'b0;
  logic tblHigh = 1'b0, tblByte = 1'b0, resetAbort = 1'b0, doneFlagClr = 1'b0;
  logic [15:0] regAddr = '0, regWrData = '0, effectiveAddr = '0, tblWrData = '0, rdWord;
  logic [7:0] tablePage = '0;
  logic [15:0] regRdData, tblRdData;
  logic tblRdValid, cpuStall, memOpDoneFlag, arrErase, arrProgram;
  logic [23:0] arrRdAddr, arrRdData, arrLatchData, pa, exp24;
  logic [ROW_W-1:0] arrRowSel;
  logic [PANEL_W-1:0] arrPanelSel;
  logic [IDX_W-1:0] arrLatchIdx;
  int mismatches = 0, checks_done = 0;
  always #20 clk_sys = ~clk_sys;
  flash_self_program_ctrl #(.OpCycles(OpCyc)) DUT (.clk_sys, .rstn, .regWr, .regRd, .regAddr, .regWrData,
    .regRdData, .tblReq, .tblWrite, .tblHigh, .tblByte, .tablePage, .effectiveAddr, .tblWrData, .tblRdData,
    .tblRdValid, .cpuStall, .resetAbort, .doneFlagClr, .memOpDoneFlag, .arrRdAddr, .arrRdData, .arrErase,
    .arrProgram, .arrRowSel, .arrPanelSel, .arrLatchIdx, .arrLatchData);
  flash_array_model PART (.clk_sys, .arrRdAddr, .arrRdData, .arrProgram, .arrLatchIdx, .arrLatchData);
  // Compares one value.
  task automatic chk(input string name, input logic [23:0] expv, input logic [23:0] got);
    checks_done++;
    if (got !== expv) begin
      mismatches++;
      $display("FAIL %s expected %h seen %h", name, expv, got);
    end
  endtask : chk
  // One register write.
  task automatic wr(input logic [15:0] a, input logic [15:0] d);
    @(posedge clk_sys);
    regWr <= 1'b1;
    regAddr <= a;
    regWrData <= d;
    @(posedge clk_sys);
    regWr <= 1'b0;
  endtask : wr
  // Three back-to-back writes; the strobe stays up between them.
  task automatic seq3(input logic [15:0] a0, d0, a1, d1, a2, d2);
    @(posedge clk_sys);
    regWr <= 1'b1;
    {regAddr, regWrData} <= {a0, d0};
    @(posedge clk_sys);
    {regAddr, regWrData} <= {a1, d1};
    @(posedge clk_sys);
    {regAddr, regWrData} <= {a2, d2};
    @(posedge clk_sys);
    regWr <= 1'b0;
  endtask : seq3
  // Register read, checked mid-cycle.
  task automatic rdchk(input string name, input logic [15:0] a, input logic [15:0] expv);
    @(posedge clk_sys);
    regRd <= 1'b1;
    regAddr <= a;
    @(negedge clk_sys);
    chk(name, expv, regRdData);
    @(posedge clk_sys);
    regRd <= 1'b0;
  endtask : rdchk
  // Table access; a read checks its answer.
  task automatic tbl(input logic w, h, b, input logic [7:0] pg, input logic [15:0] ea, d);
    @(posedge clk_sys);
    tblReq <= 1'b1;
    tblWrite <= w;
    tblHigh <= h;
    tblByte <= b;
    tablePage <= pg;
    effectiveAddr <= ea;
    tblWrData <= d;
    @(posedge clk_sys);
    tblReq <= 1'b0;
    if (w) begin
      @(posedge clk_sys);
    end else begin
      @(negedge clk_sys);
      @(negedge clk_sys);
      chk("tblRdValid", 24'h1, tblRdValid);
      rdWord = tblRdData;
    end
  endtask : tbl
  // Waits out the stall, checks and clears the flag.
  task automatic finish_op;
    int n = 0;
    while (cpuStall !== 1'b0 && n < 200) begin
      @(negedge clk_sys);
      n++;
    end
    chk("opEnded", 24'h1, n < 200);
    chk("doneFlag", 24'h1, memOpDoneFlag);
    @(posedge clk_sys);
    doneFlagClr <= 1'b1;
    @(posedge clk_sys);
    doneFlagClr <= 1'b0;
    @(negedge clk_sys);
    chk("doneCleared", 24'h0, memOpDoneFlag);
  endtask : finish_op
  // Reset values, key and direct address writes.
  task automatic t_regs;
    rdchk("ctrlReset", OFF_OP_CONTROL, 16'h0000);
    rdchk("lowReset", OFF_ADDR_LOW, 16'h0000);
    rdchk("highReset", OFF_ADDR_HIGH, 16'h0000);
    rdchk("unmapped", 16'h0768, 16'h0000);
    wr(OFF_ADDR_LOW, 16'h1fc0);
    wr(OFF_ADDR_HIGH, 16'h0005);
    wr(OFF_UNLOCK_KEY, 16'h0055);
    rdchk("lowWrite", OFF_ADDR_LOW, 16'h1fc0);
    rdchk("highWrite", OFF_ADDR_HIGH, 16'h0005);
    rdchk("keyRead", OFF_UNLOCK_KEY, 16'h0000);
  endtask : t_regs
  // Broken unlock and missing enable are dropped.
  task automatic t_refuse;
    seq3(OFF_UNLOCK_KEY, 16'h0055, OFF_ADDR_LOW, 16'h1fc0, OFF_UNLOCK_KEY, 16'h00aa);
    wr(OFF_OP_CONTROL, 16'hc041);
    rdchk("startNoUnlock", OFF_OP_CONTROL, 16'h4041);
    seq3(OFF_UNLOCK_KEY, 16'h0055, OFF_UNLOCK_KEY, 16'h00aa, OFF_OP_CONTROL, 16'h8041);
    rdchk("startNoEnable", OFF_OP_CONTROL, 16'h0041);
    chk("noDone", 24'h0, memOpDoneFlag);
  endtask : t_refuse
  // Row erase at a directly written address.
  task automatic t_erase;
    pa = 24'h051fc0;
    seq3(OFF_UNLOCK_KEY, 16'h0055, OFF_UNLOCK_KEY, 16'h00aa, OFF_OP_CONTROL, 16'hc041);
    @(negedge clk_sys);
    chk("eraseStall", 24'h1, {arrErase, cpuStall} == 2'b11);
    chk("eraseRow", pa[12:6], arrRowSel);
    chk("erasePanel", pa[23:13], arrPanelSel);
    finish_op();
    rdchk("startCleared", OFF_OP_CONTROL, 16'h4041);
  endtask : t_erase
  // Ordered row fill with a byte write, then program.
  task automatic t_program;
    for (int i = 0; i < ROW_WORDS; i++) begin
      tbl(1'b1, 1'b0, 1'b0, 8'h02, 16'h6040 + 16'(2 * i), 16'h1000 + 16'(i));
      if (i == 0) tbl(1'b1, 1'b0, 1'b1, 8'h02, 16'h6041, 16'hffab);
      tbl(1'b1, 1'b1, 1'b0, 8'h02, 16'h6040 + 16'(2 * i), {8'hee, 8'h40 + 8'(i)});
    end
    rdchk("lowCapture", OFF_ADDR_LOW, 16'h607e);
    rdchk("highCapture", OFF_ADDR_HIGH, 16'h0002);
    pa = 24'h02607e;
    seq3(OFF_UNLOCK_KEY, 16'h0055, OFF_UNLOCK_KEY, 16'h00aa, OFF_OP_CONTROL, 16'hc001);
    @(negedge clk_sys);
    chk("progRun", 24'h1, {arrProgram, cpuStall} == 2'b11);
    chk("progRow", pa[12:6], arrRowSel);
    finish_op();
    for (int i = 0; i < ROW_WORDS; i++) begin
      exp24 = (i == 0) ? 24'h40ab00 : {8'h40 + 8'(i), 16'h1000 + 16'(i)};
      chk("latchWord", exp24, PART.img[i]);
    end
  endtask : t_program
  // Table reads, word and byte; the model shows word address bits.
  task automatic t_read;
    pa = {8'he5, 16'h891a ^ 16'h5a5a};
    tbl(1'b0, 1'b0, 1'b0, 8'h03, 16'h1234, 16'h0000);
    chk("readLow", pa[15:0], rdWord);
    tbl(1'b0, 1'b1, 1'b0, 8'h03, 16'h1234, 16'h0000);
    chk("readHigh", {8'h00, pa[23:16]}, rdWord);
    tbl(1'b0, 1'b0, 1'b1, 8'h03, 16'h1235, 16'h0000);
    chk("readLowOdd", {8'h00, pa[15:8]}, rdWord);
    tbl(1'b0, 1'b1, 1'b1, 8'h03, 16'h1235, 16'h0000);
    chk("readHighOdd", 24'h0, rdWord);
  endtask : t_read
  // Mid-erase abort sets error, keeps address.
  task automatic t_abort;
    seq3(OFF_UNLOCK_KEY, 16'h0055, OFF_UNLOCK_KEY, 16'h00aa, OFF_OP_CONTROL, 16'hc041);
    repeat (3) @(posedge clk_sys);
    resetAbort <= 1'b1;
    @(posedge clk_sys);
    resetAbort <= 1'b0;
    repeat (4) @(negedge clk_sys);
    chk("abortStall", 24'h0, cpuStall);
    rdchk("errorBit", OFF_OP_CONTROL, 16'h6041);
    rdchk("addrKept", OFF_ADDR_LOW, 16'h1235);
  endtask : t_abort
  // Counts, verdict, stop.
  task automatic final_report;
    $display("checks_done %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : final_report
  // Main sequence.
  initial begin
    repeat (20) @(posedge clk_sys);
    rstn <= 1'b1;
    t_regs();
    t_refuse();
    t_erase();
    t_program();
    t_read();
    t_abort();
    final_report();
  end
  // Watchdog at 20000 cycles, far past the run.
  initial begin
    #800000;
    mismatches++;
    final_report();
  end
endmodule : flash_self_program_ctrl_tb
bind flash_self_program_ctrl flash_ctrl_assertions #(.OpCycles(OpCycles)) CHK (.clk_sys, .rstn, .regWr, .regRd,
  .regAddr, .regWrData, .regRdData, .tblReq, .tblWrite, .tblRdValid, .cpuStall, .resetAbort, .doneFlagClr,
  .memOpDoneFlag, .arrErase, .arrProgram);
